// ### bench/mct_sig_src.sv
// Signal source that stands in for the trigger comparator output.
`timescale 1ns/1ps
module mct_sig_src (
	input wire logic clk_in, // Core clock.
	input wire logic on_in, // Run the waveform.
	input wire logic [7:0] per_in, // Period in clocks.
	input wire logic [7:0] high_in, // High time in clocks.
	output logic sig_out // Comparator level.
);
	logic [7:0] ph;
	// A stopped source rests low, as a quiet comparator would.
	always @(posedge clk_in) begin
		if (!on_in) begin
			ph <= 8'h00;
			sig_out <= 1'b0;
		end else begin
			ph <= (ph + 8'h01 >= per_in) ? 8'h00 : ph + 8'h01;
			sig_out <= ph < high_in;
		end
	end
endmodule

// ### bench/mct_top_asserts.sv
// Port checker for the measurement counter/timer.
`timescale 1ns/1ps
module mct_top_asserts #(
	parameter int unsigned DISPLAY_CYCLES = 20,
	parameter int unsigned PROC_CYCLES = 10,
	parameter int unsigned RATE_CYCLES = 30
) (
	input wire logic CORE_CLK_IN, // Clock.
	input wire logic RESET_IN, // Reset.
	input wire logic PSEL_IN, // Select.
	input wire logic PENABLE_IN, // Access.
	input wire logic PWRITE_IN, // Write.
	input wire logic [7:0] PADDR_IN, // Address.
	input wire logic [31:0] PWDATA_IN, // Write data.
	input wire logic [31:0] PRDATA_OUT, // Read data.
	input wire logic PREADY_OUT, // Ready.
	input wire logic PSLVERR_OUT, // Error.
	input wire logic TRIG_IN, // Trigger.
	input wire logic [7:0] TRIG_LEVEL_OUT, // Level.
	input wire logic GEN_HALT_OUT, // Halt.
	input wire logic PURGE_OUT, // Purge.
	input wire logic GATE_OPEN_OUT, // Gate.
	input wire logic RESULT_VALID_OUT // Result.
);
	import mct_pkg::*;
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RESET_IN);
	// Completed transfers, decoded once for all properties.
	wire done = PSEL_IN && PENABLE_IN && PREADY_OUT;
	wire wr = done && PWRITE_IN;
	wire wr_ctl = wr && (PADDR_IN == OFS_CTRL || PADDR_IN == OFS_CMD);
	wire rd_res = done && !PWRITE_IN && PADDR_IN == OFS_RESULT;
	logic hold_q, ticket;
	logic [2:0] fn_q;
	logic [31:0] gate_q, open_n, since_n, low_n;
	// Shadow settings; control writes void the spacing and read ticket.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			hold_q <= 1'b0;
			fn_q <= 3'h0;
			gate_q <= GATE_RST;
			open_n <= 32'h0;
			since_n <= 32'hffffffff;
			low_n <= 32'hffffffff;
			ticket <= 1'b0;
		end else begin
			if (wr && PADDR_IN == OFS_CTRL) begin
				hold_q <= PWDATA_IN[CTRL_HOLD_BIT];
				if (PWDATA_IN[3:1] <= 3'h4)
					fn_q <= PWDATA_IN[3:1];
			end
			if (wr && PADDR_IN == OFS_GATE)
				gate_q <= (PWDATA_IN == 32'h0) ? 32'h1 : PWDATA_IN;
			open_n <= GATE_OPEN_OUT ? open_n + 32'h1 : 32'h0;
			if (wr_ctl)
				since_n <= 32'hffffffff;
			else if ($rose(GATE_OPEN_OUT))
				since_n <= 32'h1;
			else if (since_n != 32'hffffffff)
				since_n <= since_n + 32'h1;
			// Closed-gate cycles; a control write voids the spacing rule.
			if (wr_ctl)
				low_n <= 32'hffffffff;
			else if (GATE_OPEN_OUT)
				low_n <= 32'h0;
			else if (low_n != 32'hffffffff)
				low_n <= low_n + 32'h1;
			if (wr_ctl || $rose(GATE_OPEN_OUT))
				ticket <= 1'b0;
			else if (rd_res)
				ticket <= 1'b1;
		end
	end
	sequence apb_wait_s;
		PENABLE_IN && !PREADY_OUT ##1 PREADY_OUT;
	endsequence
	ready_wait_a: assert property (PSEL_IN && !PENABLE_IN |=> apb_wait_s)
		else $error("ready not after one wait state");
	ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held too long");
	err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("error without ready");
	purge_pulse_a: assert property (
		PURGE_OUT |=> !PURGE_OUT && GEN_HALT_OUT)
		else $error("purge pulse wrong");
	level_apply_a: assert property (
		wr && PADDR_IN == OFS_LEVEL |=> TRIG_LEVEL_OUT == $past(PWDATA_IN[7:0]))
		else $error("level not applied");
	gate_length_a: assert property (
		$fell(GATE_OPEN_OUT) && !$past(wr) |-> open_n == gate_q)
		else $error("gate length wrong");
	rate_limit_a: assert property (
		$rose(GATE_OPEN_OUT) && !hold_q |-> since_n >= RATE_CYCLES)
		else $error("gates too close");
	display_gap_a: assert property (
		$rose(GATE_OPEN_OUT) |->
		low_n >= (hold_q ? PROC_CYCLES : DISPLAY_CYCLES))
		else $error("gate before display time ran out");
	freq_wait_a: assert property (
		$rose(GATE_OPEN_OUT) && !hold_q && fn_q == 3'h0 |->
		!$past(RESULT_VALID_OUT))
		else $error("gate while result queued");
	hold_read_a: assert property (
		$rose(GATE_OPEN_OUT) && hold_q |-> ticket)
		else $error("hold gate without read");
	reset_flush_a: assert property (
		wr && PADDR_IN == OFS_CMD && PWDATA_IN[0] |=>
		!RESULT_VALID_OUT && !GATE_OPEN_OUT)
		else $error("counter reset did not flush");
endmodule
bind mct_top mct_top_asserts #(.DISPLAY_CYCLES(DISPLAY_CYCLES),
	.PROC_CYCLES(PROC_CYCLES), .RATE_CYCLES(RATE_CYCLES)) chk (
	.CORE_CLK_IN(CORE_CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
	.PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
	.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .TRIG_IN(TRIG_IN),
	.TRIG_LEVEL_OUT(TRIG_LEVEL_OUT), .GEN_HALT_OUT(GEN_HALT_OUT),
	.PURGE_OUT(PURGE_OUT), .GATE_OPEN_OUT(GATE_OPEN_OUT),
	.RESULT_VALID_OUT(RESULT_VALID_OUT));

// ### bench/mct_top_tb.sv
// Self-checking bench for the measurement counter/timer.
`timescale 1ns/1ps
module mct_top_tb;
	import mct_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic src_on = 1'b0;
	logic [7:0] src_per = 8'h0a;
	logic [7:0] src_high = 8'h04;
	logic [31:0] prdata, rd;
	logic [7:0] lvl;
	logic pready, pslverr, err, trig, halt, purge, gopen, rvalid;
	logic seen_purge = 1'b0;
	logic gate_d = 1'b0;
	int fail_count = 0;
	int comparisons = 0;
	int gate_starts = 0;
	mct_top #(.DISPLAY_CYCLES(20), .PROC_CYCLES(10), .RATE_CYCLES(30)) dut (
		.CORE_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .TRIG_IN(trig), .TRIG_LEVEL_OUT(lvl),
		.GEN_HALT_OUT(halt), .PURGE_OUT(purge), .GATE_OPEN_OUT(gopen),
		.RESULT_VALID_OUT(rvalid));
	mct_sig_src src (.clk_in(clk), .on_in(src_on), .per_in(src_per),
		.high_in(src_high), .sig_out(trig));
	always #20 clk = ~clk;
	// The purge is a single pulse, so it is latched here for later checks.
	always @(posedge clk) begin
		gate_d <= gopen;
		if (purge === 1'b1)
			seen_purge <= 1'b1;
		if (gopen === 1'b1 && gate_d === 1'b0)
			gate_starts++;
	end
	task automatic tally_and_finish();
		if (fail_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One transfer; the extra edge keeps the next setup off this step.
	// Only the watchdog ends a transfer that is never answered.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_valid(input int lim);
		int n;
		n = 0;
		while (rvalid !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(32'(rvalid), 32'h1);
	endtask
	task automatic t_reset();
		chk(32'(lvl), 32'h80);
		chk(32'(halt), 32'h0);
		apb(1'b0, OFS_GATE, 32'h0);
		chk(rd, GATE_RST);
		apb(1'b0, 8'h20, 32'h0);
		chk(32'(err), 32'h1);
		chk(rd, 32'h0);
		for (int f = 0; f < 5; f++) begin
			apb(1'b1, OFS_CTRL, 32'(f) << 1);
			apb(1'b0, OFS_CTRL, 32'h0);
			chk(rd, 32'(f) << 1);
		end
	endtask
	task automatic t_enable();
		apb(1'b1, OFS_LEVEL, 32'h3c);
		chk(32'(lvl), 32'h3c);
		apb(1'b1, OFS_GATE, 32'h28);
		apb(1'b1, OFS_CTRL, 32'h03);
		chk(32'(halt), 32'h1);
		// The latch takes the pulse at this edge; look one edge later.
		@(posedge clk);
		chk(32'(seen_purge), 32'h1);
	endtask
	task automatic t_period();
		src_on <= 1'b1;
		wait_valid(300);
		repeat (5) @(posedge clk);
		chk(32'(rvalid), 32'h1);
		apb(1'b0, OFS_RESULT, 32'h0);
		chk(rd, 32'h0a);
		chk(32'(rvalid), 32'h0);
	endtask
	task automatic t_width();
		apb(1'b1, OFS_CTRL, 32'h07);
		apb(1'b1, OFS_CMD, 32'h1);
		chk(32'(rvalid), 32'h0);
		// Code 7 is not a function, so width stays selected.
		apb(1'b1, OFS_CTRL, 32'h0f);
		wait_valid(300);
		apb(1'b0, OFS_RESULT, 32'h0);
		chk(rd, 32'h04);
	endtask
	task automatic t_freq();
		int n;
		int k;
		apb(1'b1, OFS_CTRL, 32'h01);
		apb(1'b1, OFS_CMD, 32'h1);
		wait_valid(400);
		n = gate_starts;
		repeat (150) @(posedge clk);
		chk(32'(gate_starts - n), 32'h0);
		apb(1'b0, OFS_RESULT, 32'h0);
		// Four rises in a 40-cycle gate at 25 MHz give 2.5 MHz.
		chk(rd, 32'h002625a0);
		k = 0;
		while (gate_starts == n && k < 200) begin
			@(posedge clk);
			k++;
		end
		chk(32'(gate_starts - n), 32'h1);
	endtask
	task automatic t_hold();
		int n;
		apb(1'b1, OFS_CTRL, 32'h13);
		apb(1'b1, OFS_CMD, 32'h1);
		n = gate_starts;
		repeat (100) @(posedge clk);
		chk(32'(gate_starts - n), 32'h0);
		apb(1'b0, OFS_RESULT, 32'h0);
		chk(rd, 32'h0);
		wait_valid(300);
		apb(1'b0, OFS_RESULT, 32'h0);
		chk(rd, 32'h0a);
		n = gate_starts;
		repeat (150) @(posedge clk);
		chk(32'(gate_starts - n), 32'h0);
		chk(32'(rvalid), 32'h0);
		apb(1'b1, OFS_CMD, 32'h1);
		apb(1'b0, OFS_RESULT, 32'h0);
		wait_valid(300);
	endtask
	// A 5-cycle gate cannot hold a second rise, so period gives no result.
	task automatic t_short();
		int n;
		int k;
		src_on <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h03);
		apb(1'b1, OFS_CMD, 32'h1);
		apb(1'b1, OFS_GATE, 32'h5);
		src_on <= 1'b1;
		n = gate_starts;
		k = 0;
		while (gate_starts == n && k < 100) begin
			@(posedge clk);
			k++;
		end
		repeat (20) @(posedge clk);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'h3, 32'h2);
		apb(1'b1, OFS_GATE, 32'h28);
	endtask
	// Totalize in hold mode: three rises are counted, then one gate reports.
	task automatic t_total();
		src_on <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h19);
		apb(1'b1, OFS_CMD, 32'h1);
		src_on <= 1'b1;
		repeat (25) @(posedge clk);
		src_on <= 1'b0;
		apb(1'b0, OFS_RESULT, 32'h0);
		chk(rd, 32'h0);
		wait_valid(300);
		apb(1'b0, OFS_RESULT, 32'h0);
		chk(rd, 32'h3);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_enable();
		t_period();
		t_width();
		t_freq();
		t_short();
		t_hold();
		t_total();
		tally_and_finish();
	end
	// Whole run is about a thousand cycles; this limit of 20000 cycles is far beyond it.
	initial begin
		#800000;
		fail_count++;
		tally_and_finish();
	end
endmodule

// ### logic/mct_div.sv
// Restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
module mct_div #(
	parameter int unsigned W = 64
) (
	input wire logic clk_in, // Core clock.
	input wire logic rst_in, // Synchronous reset, active high.
	input wire logic start_in, // Pulse: load operands and start.
	input wire logic [W-1:0] num_in, // Dividend.
	input wire logic [W-1:0] den_in, // Divisor, non-zero.
	output logic done_out, // One-cycle pulse when quotient is ready.
	output logic [W-1:0] quot_out // Quotient, held until next done.
);
	localparam int unsigned CW = $clog2(W) + 1;
	logic [W-1:0] rem;
	logic [W-1:0] quo;
	logic [W-1:0] den;
	logic [CW-1:0] cnt;
	logic busy;
	wire logic [W:0] shifted = {rem, quo[W-1]};
	wire logic [W:0] trial = shifted - {1'b0, den};
	wire logic fits = ~trial[W];
	wire logic [W-1:0] next_quo = {quo[W-2:0], fits};

	generate
		if (W < 2) begin : g_chk
			$error("mct_div needs W of at least 2");
		end
	endgenerate

	// Shift and subtract; a busy divider ignores a new start.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rem <= '0;
			quo <= '0;
			den <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done_out <= 1'b0;
			quot_out <= '0;
		end else begin
			done_out <= 1'b0;
			if (start_in && !busy) begin
				rem <= '0;
				quo <= num_in;
				den <= den_in;
				cnt <= CW'(W);
				busy <= 1'b1;
			end else if (busy) begin
				rem <= fits ? trial[W-1:0] : shifted[W-1:0];
				quo <= next_quo;
				cnt <= cnt - 1'b1;
				if (cnt == CW'(1)) begin
					busy <= 1'b0;
					done_out <= 1'b1;
					quot_out <= next_quo;
				end
			end
		end
	end
endmodule

// ### logic/mct_edge.sv
// Edge detector for the trigger comparator output.
`timescale 1ns/1ps
module mct_edge (
	input wire logic clk_in, // Core clock.
	input wire logic rst_in, // Synchronous reset, active high.
	input wire logic sig_in, // Comparator level, synchronous.
	output logic rise_out, // One-cycle pulse on a rising crossing.
	output logic fall_out // One-cycle pulse on a falling crossing.
);
	logic prev;

	// The previous level; reset low so a high input at release is a crossing.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prev <= 1'b0;
		end else begin
			prev <= sig_in;
		end
	end

	// Crossings of the programmed trigger level.
	assign rise_out = sig_in & ~prev;
	assign fall_out = ~sig_in & prev;
endmodule

// ### logic/mct_pkg.sv
// Constants and types shared by the measurement counter/timer.
// Behaviour
// - Entering counter mode halts waveform generation and purges memory.
// - Five functions exist: frequency, period, averaged period, width, total.
// - Software sets function, gate time and trigger level for later readings.
// - Frequency readings queue one at a time; the next waits for a read.
// - Totalize adds one for every qualifying trigger edge.
// - Normal display mode repeats measurements with no software action.
// - Hold mode makes exactly one measurement when a result read asks.
// - In hold mode a counter reset must come before the next measurement.
// - Counter reset clears the counting logic, flushes the queue and arms.
// - Normal mode shows each result for about 300 ms before the next gate.
// - Normal mode never delivers more than three results per second.
// - A hold reading starts at a valid trigger edge, or at once for totalize, and ends at gate close.
// - Hold mode processes each reading for about 100 ms, ten per second.
// - A gate too short for enough edges still opens but yields no result.
// - A frequency or hold-mode result is kept until software reads it; others are replaced by the next result.
package mct_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned DISPLAY_MS = 300;
	localparam int unsigned PROC_MS = 100;
	localparam int unsigned MAX_RESULTS_PER_S = 3;
	localparam int unsigned DISPLAY_CYC = CLK_HZ / 1000 * DISPLAY_MS;
	localparam int unsigned PROC_CYC = CLK_HZ / 1000 * PROC_MS;
	localparam int unsigned RATE_CYC =
		(CLK_HZ + MAX_RESULTS_PER_S - 1) / MAX_RESULTS_PER_S;
	localparam int unsigned DIV_W = 64;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GATE = 8'h04;
	localparam logic [7:0] OFS_LEVEL = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RESULT = 8'h14;

	// Field positions.
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_FN_LSB = 1;
	localparam int unsigned CTRL_HOLD_BIT = 4;
	localparam int unsigned CMD_RESET_BIT = 0;
	localparam int unsigned ST_STATE_LSB = 8;

	// Values after reset: 100 ms gate, mid-scale trigger level.
	localparam logic [31:0] GATE_RST = 32'h002625a0;
	localparam logic [7:0] LEVEL_RST = 8'h80;

	typedef enum logic [2:0] {
		MCT_FREQ = 3'h0,
		MCT_PER = 3'h1,
		MCT_APER = 3'h2,
		MCT_PULS = 3'h3,
		MCT_TOT = 3'h4
	} mct_fn_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARM = 5'h02,
		ST_GATE = 5'h04,
		ST_CALC = 5'h08,
		ST_PROC = 5'h10
	} mct_state_t;
endpackage

// ### logic/mct_top.sv
// Measurement counter/timer with its APB register slave.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module mct_top #(
	parameter int unsigned DISPLAY_CYCLES = mct_pkg::DISPLAY_CYC,
	parameter int unsigned PROC_CYCLES = mct_pkg::PROC_CYC,
	parameter int unsigned RATE_CYCLES = mct_pkg::RATE_CYC
) (
	input wire logic CORE_CLK_IN, // Core clock, 25 MHz.
	input wire logic RESET_IN, // Synchronous reset, active high.
	input wire logic PSEL_IN, // APB select.
	input wire logic PENABLE_IN, // APB access phase.
	input wire logic PWRITE_IN, // APB direction, high for write.
	input wire logic [7:0] PADDR_IN, // APB byte address.
	input wire logic [31:0] PWDATA_IN, // APB write data.
	output logic [31:0] PRDATA_OUT, // APB read data.
	output logic PREADY_OUT, // APB ready.
	output logic PSLVERR_OUT, // APB error on unmapped address.
	input wire logic TRIG_IN, // Trigger comparator output.
	output logic [7:0] TRIG_LEVEL_OUT, // Level for the trigger comparator.
	output logic GEN_HALT_OUT, // Waveform generation stopped.
	output logic PURGE_OUT, // Pulse: purge waveform memory.
	output logic GATE_OPEN_OUT, // Measurement gate open.
	output logic RESULT_VALID_OUT // Output queue holds a result.
);
	import mct_pkg::*;

	logic ctrl_en;
	mct_fn_t ctrl_fn;
	logic ctrl_hold;
	logic [31:0] gate_time;
	mct_state_t state;
	mct_state_t next_state;
	mct_fn_t cur_fn;
	logic armed;
	logic no_res;
	logic [31:0] result;
	logic [31:0] t_cnt;
	logic [31:0] edges;
	logic [31:0] last_rise;
	logic [31:0] per_val;
	logic [31:0] width_val;
	logic have_per;
	logic have_fall;
	logic [31:0] total;
	logic [31:0] dly_cnt;
	logic [31:0] rate_cnt;
	logic calc_started;
	logic rise;
	logic fall;
	logic div_done;
	logic [DIV_W-1:0] quot;

	generate
		if (DISPLAY_CYCLES < 1 || PROC_CYCLES < 1 || RATE_CYCLES < 1) begin : g_chk
			$error("mct_top cycle counts must be at least 1");
		end
	endgenerate

	// Only codes of the five functions are accepted into the control field.
	function automatic logic fn_ok(input logic [2:0] code);
		fn_ok = (code <= MCT_TOT);
	endfunction

	// Functions whose result needs the divider.
	function automatic logic fn_div(input mct_fn_t fn);
		fn_div = (fn == MCT_FREQ) || (fn == MCT_APER);
	endfunction

	// APB decode; side effects act only at the completing edge.
	wire logic acc = PSEL_IN & PENABLE_IN;
	wire logic first_acc = acc & ~PREADY_OUT;
	wire logic done_acc = acc & PREADY_OUT;
	wire logic wr = done_acc & PWRITE_IN;
	wire logic rd = done_acc & ~PWRITE_IN;
	wire logic hit_ctrl = PADDR_IN == OFS_CTRL;
	wire logic hit_gate = PADDR_IN == OFS_GATE;
	wire logic hit_level = PADDR_IN == OFS_LEVEL;
	wire logic hit_cmd = PADDR_IN == OFS_CMD;
	wire logic hit_status = PADDR_IN == OFS_STATUS;
	wire logic hit_result = PADDR_IN == OFS_RESULT;
	wire logic mapped = hit_ctrl | hit_gate | hit_level | hit_cmd |
		hit_status | hit_result;
	wire logic [2:0] wr_fn = PWDATA_IN[CTRL_FN_LSB +: 3];

	// Mode entry and the counter reset command.
	wire logic en_rise = wr & hit_ctrl & PWDATA_IN[CTRL_EN_BIT] & ~ctrl_en;
	wire logic cnt_reset = en_rise | (wr & hit_cmd & PWDATA_IN[CMD_RESET_BIT]);
	wire logic res_read = rd & hit_result;
	wire logic hold_go = ctrl_hold & armed & res_read;
	wire logic freq_blocked = (ctrl_fn == MCT_FREQ) & RESULT_VALID_OUT;
	wire logic norm_go = ~ctrl_hold & (rate_cnt == 32'h0) &
		(dly_cnt == 32'h0) & ~freq_blocked;
	wire logic gate_end = t_cnt >= gate_time - 32'h1;

	// Result of the closed gate and whether enough edges passed.
	wire logic short_gate = ((cur_fn == MCT_FREQ) && (edges == 32'h0)) ||
		((cur_fn == MCT_APER) && (edges == 32'h0)) ||
		((cur_fn == MCT_PER) && !have_per) ||
		((cur_fn == MCT_PULS) && !have_fall);
	wire logic [DIV_W-1:0] div_num = (cur_fn == MCT_FREQ) ?
		64'({32'h0, edges} * 64'(CLK_HZ)) : {32'h0, last_rise};
	wire logic [DIV_W-1:0] div_den = (cur_fn == MCT_FREQ) ?
		{32'h0, gate_time} : {32'h0, edges};
	wire logic div_start = (state == ST_CALC) & ~calc_started &
		~short_gate & fn_div(cur_fn);
	wire logic calc_done = (state == ST_CALC) &
		(short_gate | ~fn_div(cur_fn) | div_done);
	wire logic [31:0] calc_val = (cur_fn == MCT_PER) ? per_val :
		(cur_fn == MCT_PULS) ? width_val :
		(cur_fn == MCT_TOT) ? total : quot[31:0];
	wire logic [31:0] status_word = {19'h0, state, 4'h0,
		state != ST_IDLE, armed, no_res, RESULT_VALID_OUT};

	// Read data for the addressed register; unmapped words read as zero.
	wire logic [31:0] rdata = hit_ctrl ? {27'h0, ctrl_hold, ctrl_fn, ctrl_en} :
		hit_gate ? gate_time :
		hit_level ? {24'h0, TRIG_LEVEL_OUT} :
		hit_status ? status_word :
		hit_result ? result : 32'h0;

	mct_edge u_edge (
		.clk_in(CORE_CLK_IN),
		.rst_in(RESET_IN),
		.sig_in(TRIG_IN),
		.rise_out(rise),
		.fall_out(fall)
	);

	mct_div #(
		.W(DIV_W)
	) u_div (
		.clk_in(CORE_CLK_IN),
		.rst_in(RESET_IN),
		.start_in(div_start),
		.num_in(div_num),
		.den_in(div_den),
		.done_out(div_done),
		.quot_out(quot)
	);

	// APB answer: ready one cycle into the access phase, no wait beyond.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			PREADY_OUT <= 1'b0;
			PRDATA_OUT <= 32'h0;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT <= first_acc;
			PSLVERR_OUT <= first_acc & ~mapped;
			if (first_acc && !PWRITE_IN) begin
				PRDATA_OUT <= rdata;
			end
		end
	end

	// Software-written settings; a zero gate time is stored as one cycle.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			ctrl_en <= 1'b0;
			ctrl_fn <= MCT_FREQ;
			ctrl_hold <= 1'b0;
			gate_time <= GATE_RST;
			TRIG_LEVEL_OUT <= LEVEL_RST;
		end else if (wr) begin
			if (hit_ctrl) begin
				ctrl_en <= PWDATA_IN[CTRL_EN_BIT];
				ctrl_hold <= PWDATA_IN[CTRL_HOLD_BIT];
				if (fn_ok(wr_fn)) begin
					ctrl_fn <= mct_fn_t'(wr_fn);
				end
			end
			if (hit_gate) begin
				gate_time <= (PWDATA_IN == 32'h0) ? 32'h1 : PWDATA_IN;
			end
			if (hit_level) begin
				TRIG_LEVEL_OUT <= PWDATA_IN[7:0];
			end
		end
	end

	// Waveform side is held off and purged on entry to counter mode.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			GEN_HALT_OUT <= 1'b0;
			PURGE_OUT <= 1'b0;
		end else begin
			GEN_HALT_OUT <= ctrl_en | en_rise;
			PURGE_OUT <= en_rise;
		end
	end

	// Sequencer: a reset or leaving the mode always returns to idle.
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (hold_go || norm_go) begin
					next_state = ST_ARM;
				end
			end
			ST_ARM: begin
				if (ctrl_fn == MCT_TOT || rise) begin
					next_state = ST_GATE;
				end
			end
			ST_GATE: begin
				if (gate_end) begin
					next_state = ST_CALC;
				end
			end
			ST_CALC: begin
				if (calc_done) begin
					next_state = ST_PROC;
				end
			end
			ST_PROC: begin
				if (dly_cnt == 32'h0) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (!ctrl_en || cnt_reset) begin
			next_state = ST_IDLE;
		end
	end

	// State, gate output and the hold-mode arming flag.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			state <= ST_IDLE;
			GATE_OPEN_OUT <= 1'b0;
			armed <= 1'b0;
			calc_started <= 1'b0;
		end else begin
			state <= next_state;
			GATE_OPEN_OUT <= next_state == ST_GATE;
			calc_started <= state == ST_CALC;
			if (cnt_reset) begin
				armed <= 1'b1;
			end else if (hold_go) begin
				armed <= 1'b0;
			end
		end
	end

	// Gate counters; time is in reference cycles since the opening edge.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN || cnt_reset) begin
			cur_fn <= MCT_FREQ;
			t_cnt <= 32'h0;
			edges <= 32'h0;
			last_rise <= 32'h0;
			per_val <= 32'h0;
			width_val <= 32'h0;
			have_per <= 1'b0;
			have_fall <= 1'b0;
		end else if (state == ST_ARM) begin
			cur_fn <= ctrl_fn;
			t_cnt <= 32'h0;
			edges <= 32'h0;
			last_rise <= 32'h0;
			have_per <= 1'b0;
			have_fall <= 1'b0;
		end else if (state == ST_GATE) begin
			t_cnt <= t_cnt + 32'h1;
			if (rise) begin
				edges <= edges + 32'h1;
				last_rise <= t_cnt + 32'h1;
				if (!have_per) begin
					per_val <= t_cnt + 32'h1;
					have_per <= 1'b1;
				end
			end
			if (fall && !have_fall) begin
				width_val <= t_cnt + 32'h1;
				have_fall <= 1'b1;
			end
		end
	end

	// Totalize runs across gates and only a counter reset clears it.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN || cnt_reset) begin
			total <= 32'h0;
		end else if (ctrl_en && ctrl_fn == MCT_TOT && rise) begin
			total <= total + 32'h1;
		end
	end

	// Display or processing delay after each gate, and the rate floor.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN || cnt_reset) begin
			dly_cnt <= 32'h0;
			rate_cnt <= 32'h0;
		end else begin
			if (calc_done) begin
				dly_cnt <= ctrl_hold ? 32'(PROC_CYCLES - 1) :
					32'(DISPLAY_CYCLES - 1);
			end else if (dly_cnt != 32'h0) begin
				dly_cnt <= dly_cnt - 32'h1;
			end
			if (state == ST_ARM && next_state == ST_GATE) begin
				rate_cnt <= 32'(RATE_CYCLES - 1);
			end else if (rate_cnt != 32'h0) begin
				rate_cnt <= rate_cnt - 32'h1;
			end
		end
	end

	// One-entry output queue; a push in the cycle of a read wins.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN || cnt_reset) begin
			result <= 32'h0;
			RESULT_VALID_OUT <= 1'b0;
			no_res <= 1'b0;
		end else if (calc_done) begin
			no_res <= short_gate;
			if (!short_gate) begin
				result <= calc_val;
				RESULT_VALID_OUT <= 1'b1;
			end else if (res_read) begin
				RESULT_VALID_OUT <= 1'b0;
			end
		end else if (res_read) begin
			RESULT_VALID_OUT <= 1'b0;
		end
	end
endmodule
